// File: dds_chan_pkg.sv
package dds_chan_pkg;

  localparam int NUM_CHAN = 4;

  // Register addresses on the write port
  localparam logic [7:0] ADDR_FUNC  = 8'h03;
  localparam logic [7:0] ADDR_FREQ  = 8'h04;
  localparam logic [7:0] ADDR_PHASE = 8'h05;
  localparam logic [7:0] ADDR_AMPL  = 8'h06;
  localparam logic [7:0] ADDR_RAMP  = 8'h07;
  localparam logic [7:0] ADDR_RISE  = 8'h08;
  localparam logic [7:0] ADDR_FALL  = 8'h09;

  // Channel function control fields
  localparam int FN_SINE       = 0;
  localparam int FN_CLR_PHASE  = 1;
  localparam int FN_AUTO_PHASE = 2;
  localparam int FN_CLR_SWEEP  = 3;
  localparam int FN_AUTO_SWEEP = 4;
  localparam int FN_MATCH_PIPE = 5;
  localparam int FN_DAC_PD     = 6;
  localparam int FN_CORE_PD    = 7;
  localparam int FN_LSB_LO     = 8;
  localparam int FN_MUST_ZERO  = 10;
  localparam int FN_SWEEP_LOAD = 13;
  localparam int FN_SWEEP_EN   = 14;
  localparam int FN_NO_DWELL   = 15;
  localparam int FN_ALIGN_LO   = 16;
  localparam int FN_MOD_LO     = 22;
  // Writable bits; 12:11 and 21:19 unused, 10 forced low
  localparam logic [23:0] FUNC_MASK = 24'hc7e3ff;

  // Amplitude control fields
  localparam int AC_SCALE_LO  = 0;
  localparam int AC_RATE_LOAD = 10;
  localparam int AC_AUTO_RAMP = 11;
  localparam int AC_MULT_EN   = 12;
  localparam int AC_STEP_LO   = 14;
  localparam int AC_RATE_LO   = 16;
  localparam logic [23:0] AMPL_MASK = 24'hffdfff;

  localparam logic [15:0] PHASE_MASK = 16'h3fff;

  localparam logic [23:0] FUNC_RST  = 24'h000000;
  localparam logic [31:0] FREQ_RST  = 32'h00000000;
  localparam logic [15:0] PHASE_RST = 16'h0000;
  localparam logic [23:0] AMPL_RST  = 24'h000000;
  localparam logic [15:0] RAMP_RST  = 16'h0000;
  localparam logic [31:0] DELTA_RST = 32'h00000000;

  // Timer count at which a ramp timer reloads
  localparam logic [15:0] TIMER_END = 16'h0001;

  typedef struct packed {
    logic [23:0] func;
    logic [31:0] freq;
    logic [15:0] phase;
    logic [23:0] ampl;
    logic [15:0] ramp;
    logic [31:0] rise;
    logic [31:0] fall;
  } chan_regs_t;

  typedef struct packed {
    logic        valid;
    logic [7:0]  addr;
    logic [31:0] data;
  } reg_write_t;

  typedef struct packed {
    logic        sine_sel;
    logic        phase_clear;
    logic        phase_load_zero;
    logic        sweep_clear;
    logic        sweep_load_zero;
    logic        match_pipe;
    logic        dac_power_down;
    logic        core_power_down;
    logic [1:0]  dac_lsb;
    logic        sweep_active;
    logic        no_dwell;
    logic [2:0]  align;
    logic [1:0]  mod_sel;
    logic [31:0] freq_word;
    logic [13:0] phase_word;
    logic [9:0]  scale;
    logic        mult_clock_en;
    logic        mult_bypass;
    logic        auto_ramp;
    logic        manual_ramp;
    logic [1:0]  ampl_step;
    logic [31:0] rise_delta;
    logic [31:0] fall_delta;
    logic        sweep_tick;
    logic        ampl_tick;
  } chan_ctrl_t;

  typedef enum logic [1:0] {
    MOD_OFF   = 2'b00,
    MOD_AMPL  = 2'b01,
    MOD_FREQ  = 2'b10,
    MOD_PHASE = 2'b11
  } mod_sel_t;

endpackage

// File: dds_channel_control_regs.sv
`timescale 1ns/10ps
// Functional notes
// - Global auto-clear zeros sweep accumulator on commit
// - Function bit 0 picks cosine or sine
// - Function bit 1 holds phase accumulator cleared
// - Function bit 2 zeros phase accumulator on commit
// - Function bit 3 holds sweep accumulator cleared
// - Function bit 4 zeros sweep accumulator on commit
// - Function bit 5 enables matched pipeline delay
// - Function bit 6 powers down the DAC
// - Function bit 7 powers down digital core
// - Sweep timer reloads at one, optionally on commit
// - Function bit 14 enables linear sweep stepping
// - No-dwell ignored while sweep disabled
// - Modulation select, alignment, unused bits in function
// - Per-channel 32-bit frequency word
// - Per-channel 14-bit phase offset word
// - Amplitude scale; bit 12 enables multiplier
// - Amplitude timer reloads at one; if bit 10 set, also on commit or profile
// - Bit 11 picks auto or manual ramp
// - Amplitude step size and ramp rate fields
// - Sweep ramp rate holds rising interval
// - Per-channel 32-bit rising delta word
// - Per-channel 32-bit falling delta word
// - Writes steered by channel enable bits
module dds_channel_control_regs
  import dds_chan_pkg::*;
(
  input  wire logic                       clock_i,
  input  wire logic                       rst_i,
  input  wire logic                       enable_i,
  input  wire dds_chan_pkg::reg_write_t   write_i,
  input  wire logic [3:0]                 chan_enable_i,
  input  wire logic                       auto_clear_sweep_i,
  input  wire logic                       commit_i,
  input  wire logic                       profile_change_i,
  output dds_chan_pkg::chan_ctrl_t        ctrl_o [NUM_CHAN],
  output dds_chan_pkg::chan_regs_t        active_o [NUM_CHAN]
);
  import dds_chan_pkg::*;

  logic commit_q;
  logic commit_rise;

  // Commit acts on the rising edge of the strobe
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      commit_q <= 1'b0;
    end else if (enable_i) begin
      commit_q <= commit_i;
    end
  end
  assign commit_rise = commit_i & ~commit_q;

  // Register selects decoded from the write address
  logic sel_func;
  logic sel_freq;
  logic sel_phase;
  logic sel_ampl;
  logic sel_ramp;
  logic sel_rise;
  logic sel_fall;

  assign sel_func  = (write_i.addr == ADDR_FUNC);
  assign sel_freq  = (write_i.addr == ADDR_FREQ);
  assign sel_phase = (write_i.addr == ADDR_PHASE);
  assign sel_ampl  = (write_i.addr == ADDR_AMPL);
  assign sel_ramp  = (write_i.addr == ADDR_RAMP);
  assign sel_rise  = (write_i.addr == ADDR_RISE);
  assign sel_fall  = (write_i.addr == ADDR_FALL);

  genvar ch;
  generate
    for (ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
      chan_regs_t  buf_q;
      chan_regs_t  act_q;
      // Per-field buffered and active registers
      logic [23:0] buf_func_q;
      logic [31:0] buf_freq_q;
      logic [15:0] buf_phase_q;
      logic [23:0] buf_ampl_q;
      logic [15:0] buf_ramp_q;
      logic [31:0] buf_rise_q;
      logic [31:0] buf_fall_q;
      logic [23:0] act_func_q;
      logic [31:0] act_freq_q;
      logic [15:0] act_phase_q;
      logic [23:0] act_ampl_q;
      logic [15:0] act_ramp_q;
      logic [31:0] act_rise_q;
      logic [31:0] act_fall_q;
      // Timer reload conditions
      logic        sweep_commit_load;
      logic        sweep_timeout;
      logic        ampl_commit_load;
      logic        ampl_timeout;
      logic        phase_zero_q;
      logic        sweep_zero_q;
      logic [15:0] sweep_timer_q;
      logic [15:0] sweep_timer_d;
      logic [15:0] ampl_timer_q;
      logic [15:0] ampl_timer_d;
      logic        sweep_tick_d;
      logic        ampl_tick_d;
      logic        sweep_tick_q;
      logic        ampl_tick_q;
      logic        wr;

      // Channel steering
      assign wr = write_i.valid & chan_enable_i[ch];

      // Buffered copies of host writes
      // Function word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_func_q <= FUNC_RST;
        end else if (enable_i && wr && sel_func) begin
          buf_func_q <= write_i.data[23:0] & FUNC_MASK;
        end
      end

      // Frequency word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_freq_q <= FREQ_RST;
        end else if (enable_i && wr && sel_freq) begin
          buf_freq_q <= write_i.data;
        end
      end

      // Phase offset word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_phase_q <= PHASE_RST;
        end else if (enable_i && wr && sel_phase) begin
          buf_phase_q <= write_i.data[15:0] & PHASE_MASK;
        end
      end

      // Amplitude control
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_ampl_q <= AMPL_RST;
        end else if (enable_i && wr && sel_ampl) begin
          buf_ampl_q <= write_i.data[23:0] & AMPL_MASK;
        end
      end

      // Sweep ramp rate
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_ramp_q <= RAMP_RST;
        end else if (enable_i && wr && sel_ramp) begin
          buf_ramp_q <= write_i.data[15:0];
        end
      end

      // Rising delta word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_rise_q <= DELTA_RST;
        end else if (enable_i && wr && sel_rise) begin
          buf_rise_q <= write_i.data;
        end
      end

      // Falling delta word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          buf_fall_q <= DELTA_RST;
        end else if (enable_i && wr && sel_fall) begin
          buf_fall_q <= write_i.data;
        end
      end

      assign buf_q = {buf_func_q, buf_freq_q, buf_phase_q, buf_ampl_q,
                      buf_ramp_q, buf_rise_q, buf_fall_q};

      // Active copies updated together on commit
      // Function word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_func_q <= FUNC_RST;
        end else if (enable_i && commit_rise) begin
          act_func_q <= buf_func_q;
        end
      end

      // Frequency word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_freq_q <= FREQ_RST;
        end else if (enable_i && commit_rise) begin
          act_freq_q <= buf_freq_q;
        end
      end

      // Phase offset word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_phase_q <= PHASE_RST;
        end else if (enable_i && commit_rise) begin
          act_phase_q <= buf_phase_q;
        end
      end

      // Amplitude control
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_ampl_q <= AMPL_RST;
        end else if (enable_i && commit_rise) begin
          act_ampl_q <= buf_ampl_q;
        end
      end

      // Sweep ramp rate
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_ramp_q <= RAMP_RST;
        end else if (enable_i && commit_rise) begin
          act_ramp_q <= buf_ramp_q;
        end
      end

      // Rising delta word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_rise_q <= DELTA_RST;
        end else if (enable_i && commit_rise) begin
          act_rise_q <= buf_rise_q;
        end
      end

      // Falling delta word
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          act_fall_q <= DELTA_RST;
        end else if (enable_i && commit_rise) begin
          act_fall_q <= buf_fall_q;
        end
      end

      assign act_q = {act_func_q, act_freq_q, act_phase_q, act_ampl_q,
                      act_ramp_q, act_rise_q, act_fall_q};

      // Ramp timer reload conditions
      assign sweep_commit_load = commit_rise & act_q.func[FN_SWEEP_LOAD];
      assign sweep_timeout     = (sweep_timer_q <= TIMER_END);
      assign ampl_commit_load  = (commit_rise | profile_change_i)
                                 & act_q.ampl[AC_RATE_LOAD];
      assign ampl_timeout      = (ampl_timer_q <= TIMER_END);

      // Sweep ramp-rate timer
      always_comb begin
        sweep_timer_d = sweep_timer_q;
        sweep_tick_d  = 1'b0;
        if (sweep_commit_load) begin
          sweep_timer_d = buf_q.ramp;
        end else if (sweep_timeout) begin
          sweep_timer_d = act_q.ramp;
          sweep_tick_d  = act_q.func[FN_SWEEP_EN];
        end else begin
          sweep_timer_d = sweep_timer_q - 16'h0001;
        end
      end

      // Amplitude ramp-rate timer
      always_comb begin
        ampl_timer_d = ampl_timer_q;
        ampl_tick_d  = 1'b0;
        if (ampl_commit_load) begin
          ampl_timer_d = {8'h00, buf_q.ampl[AC_RATE_LO +: 8]};
        end else if (ampl_timeout) begin
          ampl_timer_d = {8'h00, act_q.ampl[AC_RATE_LO +: 8]};
          ampl_tick_d  = act_q.ampl[AC_MULT_EN] & act_q.ampl[AC_AUTO_RAMP];
        end else begin
          ampl_timer_d = ampl_timer_q - 16'h0001;
        end
      end

      // Sweep timer count
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          sweep_timer_q <= 16'h0000;
        end else if (enable_i) begin
          sweep_timer_q <= sweep_timer_d;
        end
      end

      // Sweep step tick
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          sweep_tick_q <= 1'b0;
        end else if (enable_i) begin
          sweep_tick_q <= sweep_tick_d;
        end
      end

      // Amplitude timer count
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          ampl_timer_q <= 16'h0000;
        end else if (enable_i) begin
          ampl_timer_q <= ampl_timer_d;
        end
      end

      // Amplitude step tick
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          ampl_tick_q <= 1'b0;
        end else if (enable_i) begin
          ampl_tick_q <= ampl_tick_d;
        end
      end

      // One-cycle auto-clear pulses after commit
      // Phase accumulator zero pulse
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          phase_zero_q <= 1'b0;
        end else if (enable_i) begin
          phase_zero_q <= commit_rise & act_q.func[FN_AUTO_PHASE];
        end
      end

      // Sweep accumulator zero pulse
      always_ff @(posedge clock_i) begin
        if (rst_i) begin
          sweep_zero_q <= 1'b0;
        end else if (enable_i) begin
          sweep_zero_q <= commit_rise
                          & (act_q.func[FN_AUTO_SWEEP]
                             | auto_clear_sweep_i);
        end
      end

      // Decoded controls
      always_comb begin
        ctrl_o[ch].sine_sel        = act_q.func[FN_SINE];
        ctrl_o[ch].phase_clear     = act_q.func[FN_CLR_PHASE];
        ctrl_o[ch].phase_load_zero = phase_zero_q;
        ctrl_o[ch].sweep_clear     = act_q.func[FN_CLR_SWEEP];
        ctrl_o[ch].sweep_load_zero = sweep_zero_q;
        ctrl_o[ch].match_pipe      = act_q.func[FN_MATCH_PIPE];
        ctrl_o[ch].dac_power_down  = act_q.func[FN_DAC_PD];
        ctrl_o[ch].core_power_down = act_q.func[FN_CORE_PD];
        ctrl_o[ch].dac_lsb         = act_q.func[FN_LSB_LO +: 2];
        ctrl_o[ch].sweep_active    = act_q.func[FN_SWEEP_EN];
        ctrl_o[ch].no_dwell        = act_q.func[FN_NO_DWELL]
                                     & act_q.func[FN_SWEEP_EN];
        ctrl_o[ch].align           = act_q.func[FN_ALIGN_LO +: 3];
        ctrl_o[ch].mod_sel         = act_q.func[FN_MOD_LO +: 2];
        ctrl_o[ch].freq_word       = act_q.freq;
        ctrl_o[ch].phase_word      = act_q.phase[13:0];
        ctrl_o[ch].scale           = act_q.ampl[AC_SCALE_LO +: 10];
        ctrl_o[ch].mult_clock_en   = act_q.ampl[AC_MULT_EN];
        ctrl_o[ch].mult_bypass     = ~act_q.ampl[AC_MULT_EN];
        ctrl_o[ch].auto_ramp       = act_q.ampl[AC_MULT_EN]
                                     & act_q.ampl[AC_AUTO_RAMP];
        ctrl_o[ch].manual_ramp     = act_q.ampl[AC_MULT_EN]
                                     & ~act_q.ampl[AC_AUTO_RAMP];
        ctrl_o[ch].ampl_step       = act_q.ampl[AC_STEP_LO +: 2];
        ctrl_o[ch].rise_delta      = act_q.rise;
        ctrl_o[ch].fall_delta      = act_q.fall;
        ctrl_o[ch].sweep_tick      = sweep_tick_q;
        ctrl_o[ch].ampl_tick       = ampl_tick_q;
      end

      // Active register view
      assign active_o[ch] = act_q;
    end
  endgenerate

endmodule

// File: dds_host_model.sv
`timescale 1ns/10ps
module dds_host_model
  import dds_chan_pkg::*;
(
  input  wire logic                     clock_i,
  output dds_chan_pkg::reg_write_t      write_o,
  output logic [3:0]                    chan_enable_o,
  output logic                          commit_o,
  output logic                          auto_clear_o,
  output logic                          profile_o
);
  import dds_chan_pkg::*;

  initial begin
    write_o = '0;
    chan_enable_o = 4'hf;
    commit_o = 1'b0;
    auto_clear_o = 1'b0;
    profile_o = 1'b0;
  end

  // One register write to the channels in m
  task automatic wr(input logic [3:0] m, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clock_i);
    #1;
    if (a == ADDR_FUNC) d[FN_MUST_ZERO] = 1'b0;
    chan_enable_o = m;
    write_o = '{1'b1, a, d};
    @(posedge clock_i);
    #1;
    write_o = '{1'b0, ~a, ~d};
  endtask

  // Commit strobe, with global auto-clear level g
  task automatic commit(input logic g);
    @(posedge clock_i);
    #1;
    auto_clear_o = g;
    profile_o = g;
    commit_o = 1'b1;
    @(posedge clock_i);
    #1;
    commit_o = 1'b0;
    profile_o = 1'b0;
  endtask
endmodule

// File: dds_regs_assertions.sv
`timescale 1ns/10ps
module dds_regs_assertions
  import dds_chan_pkg::*;
(
  input  wire logic                     clock_i,
  input  wire logic                     rst_i,
  input  wire logic                     enable_i,
  input  wire logic                     commit_i,
  input  wire logic                     auto_clear_sweep_i,
  input  wire dds_chan_pkg::chan_ctrl_t ctrl_o [NUM_CHAN],
  input  wire dds_chan_pkg::chan_regs_t active_o [NUM_CHAN]
);
  import dds_chan_pkg::*;
  logic c_q;
  logic cm;
  always_ff @(posedge clock_i) begin
    if (rst_i) c_q <= 1'b0;
    else if (enable_i) c_q <= commit_i;
  end
  assign cm = enable_i & commit_i & ~c_q;
  default clocking @(posedge clock_i); endclocking
  default disable iff (rst_i);
  sequence pulse_s(x);
    ##[1:2] x;
  endsequence
  hold_active_a: assert property (
    !cm |=> $stable(active_o[0]))
    else $error("active copy changed without commit");
  sine_sel_a: assert property (
    ctrl_o[0].sine_sel == active_o[0].func[0])
    else $error("sine select wrong");
  phase_clear_a: assert property (
    ctrl_o[0].phase_clear == active_o[0].func[1])
    else $error("phase clear wrong");
  dac_down_a: assert property (
    ctrl_o[0].dac_power_down == active_o[0].func[6])
    else $error("dac power down wrong");
  core_down_a: assert property (
    ctrl_o[0].core_power_down == active_o[0].func[7])
    else $error("core power down wrong");
  auto_phase_a: assert property (
    cm && active_o[0].func[2] |-> pulse_s(ctrl_o[0].phase_load_zero))
    else $error("no phase zero pulse");
  auto_sweep_a: assert property (
    cm && active_o[0].func[4] |-> pulse_s(ctrl_o[0].sweep_load_zero))
    else $error("no sweep zero pulse");
  global_sweep_a: assert property (
    cm && auto_clear_sweep_i |-> pulse_s(ctrl_o[1].sweep_load_zero))
    else $error("no global sweep zero pulse");
  no_dwell_a: assert property (
    !active_o[0].func[14] |-> !ctrl_o[0].no_dwell)
    else $error("no dwell without sweep");
  ramp_mode_a: assert property (
    ctrl_o[0].auto_ramp
      == (active_o[0].ampl[12] && active_o[0].ampl[11]))
    else $error("auto ramp gate wrong");
endmodule

bind dds_channel_control_regs dds_regs_assertions i_chk (
  .clock_i(clock_i), .rst_i(rst_i), .enable_i(enable_i),
  .commit_i(commit_i), .auto_clear_sweep_i(auto_clear_sweep_i),
  .ctrl_o(ctrl_o), .active_o(active_o));

// File: testbench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
  $display("[ERR] %0t value mismatch", $time); end end
module testbench;
  import dds_chan_pkg::*;
  logic       clock_i = 1'b0;
  logic       rst_i = 1'b1;
  reg_write_t w;
  logic [3:0] ce;
  logic       cm;
  logic       ac;
  logic       pc;
  chan_ctrl_t ctrl [NUM_CHAN];
  chan_regs_t active [NUM_CHAN];
  int         n_fail = 0;
  int         total_checks = 0;
  int         cyc = 0;

  always #50 clock_i = ~clock_i;

  dds_host_model i_host (.clock_i(clock_i), .write_o(w), .chan_enable_o(ce),
    .commit_o(cm), .auto_clear_o(ac), .profile_o(pc));
  dds_channel_control_regs i_dut (.clock_i(clock_i), .rst_i(rst_i),
    .enable_i(1'b1), .write_i(w), .chan_enable_i(ce),
    .auto_clear_sweep_i(ac), .commit_i(cm), .profile_change_i(pc),
    .ctrl_o(ctrl), .active_o(active));

  task automatic end_sim();
    $display("checks %0d, errors %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  always @(posedge clock_i) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_sim();
    end
  end

  task automatic t_reset();
    for (int c = 0; c < NUM_CHAN; c++) `CHK(active[c], '0)
    `CHK(ctrl[0].mult_bypass, 1'b1)
  endtask

  task automatic t_buffer();
    i_host.wr(4'h1, ADDR_FREQ, 32'h12345678);
    `CHK(active[0].freq, 32'h0)
    i_host.commit(1'b0);
    `CHK(active[0].freq, 32'h12345678)
  endtask

  task automatic t_steer();
    i_host.wr(4'h5, ADDR_RISE, 32'hdeadbeef);
    i_host.wr(4'h5, ADDR_FALL, 32'hcafe0001);
    i_host.commit(1'b0);
    for (int c = 0; c < NUM_CHAN; c++) begin
      `CHK(active[c].rise, c[0] ? 32'h0 : 32'hdeadbeef)
      `CHK(active[c].fall, c[0] ? 32'h0 : 32'hcafe0001)
    end
  endtask

  task automatic t_fields();
    for (int a = 3; a <= 10; a++) i_host.wr(4'hf, a[7:0], 32'hffffffff);
    i_host.commit(1'b1);
    `CHK(active[3].func, FUNC_MASK)
    `CHK(active[3].phase, PHASE_MASK)
    `CHK(active[3].ampl, AMPL_MASK)
    `CHK(active[3].ramp, 16'hffff)
    `CHK(active[3].rise, 32'hffffffff)
    `CHK(ctrl[3].mod_sel, 2'b11)
    `CHK(ctrl[3].no_dwell, 1'b1)
    `CHK(ctrl[3].mult_bypass, 1'b0)
    `CHK(ctrl[3].auto_ramp, 1'b1)
  endtask

  task automatic t_gates();
    i_host.wr(4'hf, ADDR_FUNC, 32'h00008000);
    i_host.wr(4'hf, ADDR_AMPL, 32'h00000800);
    i_host.commit(1'b0);
    `CHK(ctrl[1].no_dwell, 1'b0)
    `CHK(ctrl[1].auto_ramp, 1'b0)
    `CHK(ctrl[1].manual_ramp, 1'b0)
    `CHK(ctrl[1].sine_sel, 1'b0)
  endtask

  task automatic t_timers();
    int ns = 0;
    int na = 0;
    i_host.wr(4'h1, ADDR_FUNC, 32'h0000e028);
    i_host.wr(4'h1, ADDR_AMPL, 32'h00031c00);
    i_host.wr(4'h1, ADDR_RAMP, 32'h00000003);
    i_host.commit(1'b0);
    i_host.commit(1'b0);
    `CHK(ctrl[0].match_pipe, 1'b1)
    `CHK(ctrl[0].sweep_clear, 1'b1)
    `CHK(ctrl[0].sweep_active, 1'b1)
    repeat (12) begin
      @(posedge clock_i);
      #1;
      ns += ctrl[0].sweep_tick;
      na += ctrl[0].ampl_tick;
    end
    `CHK(ns, 4)
    `CHK(na, 4)
  endtask

  initial begin
    repeat (6) @(posedge clock_i);
    #1;
    rst_i = 1'b0;
    t_reset();
    t_buffer();
    t_steer();
    t_fields();
    t_gates();
    t_timers();
    repeat (4) @(posedge clock_i);
    end_sim();
  end
endmodule
